// file: mub_cfg.svh
// Constants of the multi-port baud generator: offsets, fields, resets, timing.
// Assumes a 25 MHz system clock and a byte-addressed classic Wishbone slave.
`ifndef MUB_CFG_SVH
`define MUB_CFG_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define MUB_NPORTS        8
`define MUB_PORT_REGS     8
`define MUB_ADR_W         9

// ----------------------------------------------------------------------------
// Timing: crystal rate synthesised from the system clock by a phase accumulator
// ----------------------------------------------------------------------------
`define MUB_CLK_HZ        25000000
`define MUB_XTAL_HZ       14745600
`define MUB_NCO_STEP      (`MUB_XTAL_HZ / 100)
`define MUB_NCO_MOD       (`MUB_CLK_HZ / 100)

// ----------------------------------------------------------------------------
// Address map: bit 8 selects the global block, bits 7:5 port, bits 4:2 index
// ----------------------------------------------------------------------------
`define MUB_GLOBAL_BIT    8
`define MUB_IDX_DIV_LO    3'h0
`define MUB_IDX_DIV_HI    3'h1
`define MUB_IDX_SAMPLE    3'h2
`define MUB_IDX_PRESCALE  3'h3
`define MUB_IDX_STATUS    3'h4
`define MUB_IDX_ID        6'h00

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define MUB_PWR_LSB       3
`define MUB_ADD_LSB       0
`define MUB_SAMPLE_MAX    4'hc
`define MUB_SAMPLE_BASE   5'h10
`define MUB_ST_TICK_BIT   0
`define MUB_ST_ACTIVE_BIT 1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MUB_RST_DIV_LO    8'h0c
`define MUB_RST_DIV_HI    8'h00
`define MUB_RST_SAMPLE    4'h0
`define MUB_RST_PWR       5'h01
`define MUB_RST_ADD       3'h0

// ----------------------------------------------------------------------------
// Identity codes (values arbitrary)
// ----------------------------------------------------------------------------
`define MUB_VENDOR_ID     16'h5a5a
`define MUB_DEV_ID_8P     16'h0801
`define MUB_DEV_ID_4P     16'h0401

`endif

// file: mub_pkg.sv
// Types shared by the baud generator and its register front end.
// Assumes mub_cfg.svh is on the include path.
`include "mub_cfg.svh"

package mub_pkg;

  // Per-generator state
  typedef struct packed {
    logic [5:0]  pcnt;
    logic [15:0] dcnt;
    logic        strobe;
  } mub_gen_s;

  // Front end state: register file, bus answer, synchronisers, crystal phase
  typedef struct packed {
    logic [`MUB_NPORTS-1:0][7:0] div_lo;
    logic [`MUB_NPORTS-1:0][7:0] div_hi;
    logic [`MUB_NPORTS-1:0][3:0] sample;
    logic [`MUB_NPORTS-1:0][4:0] pwr;
    logic [`MUB_NPORTS-1:0][2:0] add;
    logic [`MUB_NPORTS-1:0]      tick_seen;
    logic [`MUB_NPORTS-1:0]      reload;
    logic                        ack;
    logic [31:0]                 dat;
    logic [17:0]                 phase;
    logic                        xtal_tick;
    logic                        ring_m;
    logic                        ring_s;
    logic                        l2_m;
    logic                        l2_s;
    logic                        wake;
  } mub_top_s;

endpackage

// file: mub_baud_gen.sv
// One port's baud generator: prescale counter chained into a divide counter.
// Assumes xtal_tick_i is a one-cycle pulse at the crystal rate, same clock.
`timescale 1ns/1ps
`include "mub_cfg.svh"

module mub_baud_gen
  import mub_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        xtal_tick_i,
  input  wire logic        reload_i,
  input  wire logic [15:0] div_i,
  input  wire logic [3:0]  sample_i,
  input  wire logic [4:0]  pwr_i,
  input  wire logic [2:0]  add_i,
  output logic             strobe_o,
  output logic             active_o
);

  mub_gen_s   s_ff;
  mub_gen_s   nxt_s;
  logic [4:0] samp_cnt;
  logic [5:0] base;
  logic [5:0] pre;

  // ----------------------------------------------------------------------------
  // Prescaler terms
  // ----------------------------------------------------------------------------
  // Sample count is sixteen less the setting
  assign samp_cnt = `MUB_SAMPLE_BASE - {1'b0, sample_i};
  assign base     = {1'b0, samp_cnt} + {3'h0, add_i};
  // Power one keeps the base, power two doubles it; anything else stalls
  assign pre      = (pwr_i == 5'h01) ? base :
                    (pwr_i == 5'h02) ? {base[4:0], 1'b0} : 6'h00;
  // A zero term would wrap the counters, so the generator just idles
  assign active_o = (pre != 6'h00) && (div_i != 16'h0000);

  // ----------------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------------
  // Strobe rate is crystal / (divisor * prescaler)
  always_comb
  begin
    nxt_s        = s_ff;
    nxt_s.strobe = 1'b0;
    if (reload_i || !active_o)
    begin
      nxt_s.pcnt = 6'h00;
      nxt_s.dcnt = 16'h0000;
    end
    else if (xtal_tick_i)
    begin
      if (s_ff.pcnt == pre - 6'h01)
      begin
        nxt_s.pcnt = 6'h00;
        if (s_ff.dcnt == div_i - 16'h0001)
        begin
          nxt_s.dcnt   = 16'h0000;
          nxt_s.strobe = 1'b1;
        end
        else
        begin
          nxt_s.dcnt = s_ff.dcnt + 16'h0001;
        end
      end
      else
      begin
        nxt_s.pcnt = s_ff.pcnt + 6'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign strobe_o = s_ff.strobe;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_reload_seen;
    reload_i;
  endsequence
  sequence s_counts_clear;
    (s_ff.pcnt == 6'h00) && (s_ff.dcnt == 16'h0000) && !strobe_o;
  endsequence

  property p_strobe_single;
    strobe_o |=> !strobe_o;
  endproperty
  a_strobe_single: assert property (p_strobe_single)
    else $error("baud strobe longer than one cycle");

  property p_reload_clears;
    s_reload_seen |=> s_counts_clear;
  endproperty
  a_reload_clears: assert property (p_reload_clears)
    else $error("counters not reloaded after settings write");

  property p_prescale_wrap;
    (xtal_tick_i && active_o && !reload_i && s_ff.pcnt == pre - 6'h01)
      |=> (s_ff.pcnt == 6'h00);
  endproperty
  a_prescale_wrap: assert property (p_prescale_wrap)
    else $error("prescale counter missed its terminal count");

  property p_zero_term_idle;
    !active_o |=> !strobe_o;
  endproperty
  a_zero_term_idle: assert property (p_zero_term_idle)
    else $error("strobe produced with a zero term");

  property p_strobe_cause;
    strobe_o |-> $past(xtal_tick_i) && $past(s_ff.dcnt) == $past(div_i) - 16'h0001;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause)
    else $error("strobe without divisor expiry");

endmodule

// file: mub_top.sv
// Multi-port baud generator block with its Wishbone register front end.
// Assumes a classic Wishbone master on clk_i; ring and low-power pins are async.
`timescale 1ns/1ps
`include "mub_cfg.svh"

module mub_top
  import mub_pkg::*;
#(
  parameter bit FOUR_PORT_BUILD = 1'b0,
  parameter bit WAKE_FITTED     = 1'b1
)
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [`MUB_ADR_W-1:0]  adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  input  wire logic                   ring_a_i,
  input  wire logic                   host_l2_i,
  output logic                        wake_o,
  output logic      [`MUB_NPORTS-1:0] baud_tick_o
);

  mub_top_s               s_ff;
  mub_top_s               nxt_s;
  logic [`MUB_NPORTS-1:0] strobe;
  logic [`MUB_NPORTS-1:0] active;
  logic [`MUB_NPORTS-1:0] populated;
  logic                   req;
  logic                   glob;
  logic [2:0]             port;
  logic [2:0]             idx;
  logic [18:0]            phase_sum;

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  // One new request per access; the registered ack blocks a second take
  assign req  = cyc_i && stb_i && !s_ff.ack;
  assign glob = adr_i[`MUB_GLOBAL_BIT];
  assign port = adr_i[7:5];
  assign idx  = adr_i[4:2];

  // Channels D to G are absent in the small build and read as zero
  genvar gp;
  generate
    for (gp = 0; gp < `MUB_NPORTS; gp++)
    begin : g_port
      assign populated[gp] = !FOUR_PORT_BUILD || (gp < 3) || (gp == 7);

      mub_baud_gen u_gen (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .xtal_tick_i (s_ff.xtal_tick),
        .reload_i    (s_ff.reload[gp]),
        .div_i       ({s_ff.div_hi[gp], s_ff.div_lo[gp]}),
        .sample_i    (s_ff.sample[gp]),
        .pwr_i       (s_ff.pwr[gp]),
        .add_i       (s_ff.add[gp]),
        .strobe_o    (strobe[gp]),
        .active_o    (active[gp])
      );
    end
  endgenerate

  // Crystal rate built from the system clock by a phase accumulator
  assign phase_sum = {1'b0, s_ff.phase} + 19'(`MUB_NCO_STEP);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    nxt_s        = s_ff;
    nxt_s.ack    = req;
    nxt_s.reload = '0;

    // Crystal tick: carry of the phase accumulator
    if (phase_sum >= 19'(`MUB_NCO_MOD))
    begin
      nxt_s.phase     = 18'(phase_sum - 19'(`MUB_NCO_MOD));
      nxt_s.xtal_tick = 1'b1;
    end
    else
    begin
      nxt_s.phase     = phase_sum[17:0];
      nxt_s.xtal_tick = 1'b0;
    end

    // Pin synchronisers; only the second stage is looked at
    nxt_s.ring_m = ring_a_i;
    nxt_s.ring_s = s_ff.ring_m;
    nxt_s.l2_m   = host_l2_i;
    nxt_s.l2_s   = s_ff.l2_m;
    nxt_s.wake   = WAKE_FITTED && s_ff.ring_s && s_ff.l2_s;

    // Register writes; byte lane 0 carries the 8-bit settings
    if (req && we_i && !glob && populated[port] && sel_i[0])
    begin
      case (idx)
        `MUB_IDX_DIV_LO:
        begin
          nxt_s.div_lo[port] = dat_i[7:0];
          nxt_s.reload[port] = 1'b1;
        end
        `MUB_IDX_DIV_HI:
        begin
          nxt_s.div_hi[port] = dat_i[7:0];
          nxt_s.reload[port] = 1'b1;
        end
        `MUB_IDX_SAMPLE:
        begin
          // Out-of-range settings clip so the sample count never drops below 4
          nxt_s.sample[port] = (dat_i[3:0] > `MUB_SAMPLE_MAX) ?
                               `MUB_SAMPLE_MAX : dat_i[3:0];
          nxt_s.reload[port] = 1'b1;
        end
        `MUB_IDX_PRESCALE:
        begin
          nxt_s.pwr[port]    = dat_i[`MUB_PWR_LSB +: 5];
          nxt_s.add[port]    = dat_i[`MUB_ADD_LSB +: 3];
          nxt_s.reload[port] = 1'b1;
        end
        `MUB_IDX_STATUS:
        begin
          if (dat_i[`MUB_ST_TICK_BIT])
            nxt_s.tick_seen[port] = 1'b0;
        end
        default:
        begin
          nxt_s.reload[port] = 1'b0;
        end
      endcase
    end

    // Sticky strobe flags; a new strobe beats a same-cycle clear
    nxt_s.tick_seen = nxt_s.tick_seen | strobe;

    // Read data captured with the ack
    if (req)
    begin
      nxt_s.dat = 32'h0000_0000;
      if (glob)
      begin
        if (adr_i[7:2] == `MUB_IDX_ID)
          nxt_s.dat = {FOUR_PORT_BUILD ? `MUB_DEV_ID_4P : `MUB_DEV_ID_8P,
                       `MUB_VENDOR_ID};
      end
      else if (populated[port])
      begin
        // Slots 5 to 7 stand for the remaining UART registers, read as zero
        case (idx)
          `MUB_IDX_DIV_LO:   nxt_s.dat[7:0] = s_ff.div_lo[port];
          `MUB_IDX_DIV_HI:   nxt_s.dat[7:0] = s_ff.div_hi[port];
          `MUB_IDX_SAMPLE:   nxt_s.dat[3:0] = s_ff.sample[port];
          `MUB_IDX_PRESCALE: nxt_s.dat[7:0] = {s_ff.pwr[port], s_ff.add[port]};
          `MUB_IDX_STATUS:   nxt_s.dat[1:0] = {active[port], s_ff.tick_seen[port]};
          default:           nxt_s.dat = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_ff        <= '0;
      s_ff.div_lo <= {`MUB_NPORTS{`MUB_RST_DIV_LO}};
      s_ff.div_hi <= {`MUB_NPORTS{`MUB_RST_DIV_HI}};
      s_ff.sample <= {`MUB_NPORTS{`MUB_RST_SAMPLE}};
      s_ff.pwr    <= {`MUB_NPORTS{`MUB_RST_PWR}};
      s_ff.add    <= {`MUB_NPORTS{`MUB_RST_ADD}};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // Absent channels never tick, so nothing downstream of them moves
  assign baud_tick_o = strobe & populated;
  assign ack_o       = s_ff.ack;
  assign dat_o       = s_ff.dat;
  assign wake_o      = s_ff.wake;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  property p_ack_timing;
    s_bus_req |=> s_ack_pulse;
  endproperty
  a_ack_timing: assert property (p_ack_timing)
    else $error("bus ack not a one-cycle answer after request");

  property p_unpopulated_quiet;
    FOUR_PORT_BUILD && cyc_i && stb_i && !ack_o && !glob && !populated[port]
      |=> dat_o == 32'h0;
  endproperty
  a_unpopulated_quiet: assert property (p_unpopulated_quiet)
    else $error("absent channel returned data");

  property p_wake_on_ring;
    (WAKE_FITTED && ring_a_i && host_l2_i) [*4] |-> wake_o;
  endproperty
  a_wake_on_ring: assert property (p_wake_on_ring)
    else $error("wake-up not raised for ring in low-power state");

  property p_sample_clip;
    cyc_i && stb_i && !ack_o && we_i && !glob && populated[port] && sel_i[0]
      && idx == `MUB_IDX_SAMPLE && dat_i[3:0] > `MUB_SAMPLE_MAX
      |=> s_ff.sample[$past(port)] == `MUB_SAMPLE_MAX;
  endproperty
  a_sample_clip: assert property (p_sample_clip)
    else $error("sample setting above C not clipped");

  property p_id_read;
    cyc_i && stb_i && !ack_o && !we_i && glob && adr_i[7:2] == `MUB_IDX_ID
      |=> dat_o[15:0] == `MUB_VENDOR_ID;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("vendor code not returned");

  property p_xtal_rate;
    // A tick marks exactly the wrap of the accumulator: no tick lost, none extra
    !$past(rst_i) |-> (s_ff.xtal_tick == (s_ff.phase < 18'(`MUB_NCO_STEP)));
  endproperty
  a_xtal_rate: assert property (p_xtal_rate)
    else $error("crystal tick out of step with phase accumulator");

endmodule

// file: mub_host_model.sv
// Host side bus master model: one classic Wishbone cycle per go_i pulse.
// Assumes go_i comes only while idle; released address and data lines carry inverted values.
`timescale 1ns/1ps
`include "mub_cfg.svh"

module mub_host_model
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  go_i,
  input  wire logic                  wr_i,
  input  wire logic [`MUB_ADR_W-1:0] a_i,
  input  wire logic [31:0]           wd_i,
  output logic      [31:0]           rd_o,
  output logic                       done_o,
  output logic                       cyc_o,
  output logic                       stb_o,
  output logic                       we_o,
  output logic      [`MUB_ADR_W-1:0] adr_o,
  output logic      [3:0]            sel_o,
  output logic      [31:0]           dat_o,
  input  wire logic                  ack_i,
  input  wire logic [31:0]           dat_i
);
  // ----------------------------------------------------------------------
  // Request engine
  // ----------------------------------------------------------------------
  // Request held until ack is sampled; address and data lines flip on release so stale data never looks valid
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i)
    begin
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o  <= 1'b0;
      sel_o <= 4'h0;
      adr_o <= '0;
      dat_o <= '0;
      rd_o  <= '0;
    end
    else if (cyc_o && ack_i)
    begin
      rd_o   <= dat_i;
      done_o <= 1'b1;
      cyc_o  <= 1'b0;
      stb_o  <= 1'b0;
      we_o   <= 1'b0;
      adr_o  <= ~adr_o;
      dat_o  <= ~dat_o;
    end
    else if (!cyc_o && go_i)
    begin
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= wr_i;
      sel_o <= 4'hf;
      adr_o <= a_i;
      dat_o <= wd_i;
    end
  end
endmodule

// file: mub_top_tb_top.sv
// Bench for the multi-port baud generator: registers, strobes, builds, wake-up.
// Assumes mub_cfg.svh on the include path and the host model compiled first.
`timescale 1ns/1ps
`include "mub_cfg.svh"

`define TB_CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("BAD %0t got %0h expected %0h", $time, got, exp); \
    end \
  end

module mub_top_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        go    = 1'b0;
  logic        wr    = 1'b0;
  logic        ring  = 1'b0;
  logic        l2    = 1'b0;
  logic [8:0]  a     = '0;
  logic [31:0] wd    = '0;
  logic [31:0] rd, mdat, dat8, dat4;
  logic        done, cyc, stb, we, ack8, wake8, wake4;
  logic [8:0]  adr;
  logic [3:0]  sel;
  logic [7:0]  tick8, tick4;
  logic [7:0]  v [8][4];
  logic [7:0]  lo, hi;
  logic [3:0]  sc;
  logic [4:0]  pw;
  logic [2:0]  ad;
  int          n_fail = 0;
  int          checked = 0;
  int          p, t;
  longint      e;

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  mub_host_model mub_host_model_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .wr_i(wr),
    .a_i(a), .wd_i(wd), .rd_o(rd), .done_o(done), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(mdat), .ack_i(ack8), .dat_i(dat8));
  mub_top mub_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(mdat), .dat_o(dat8), .ack_o(ack8), .ring_a_i(ring),
    .host_l2_i(l2), .wake_o(wake8), .baud_tick_o(tick8));
  // Four-port build without the wake option shares the bus; same answer timing, data only
  mub_top #(.FOUR_PORT_BUILD(1'b1), .WAKE_FITTED(1'b0))
    mub_top_4_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(mdat), .dat_o(dat4),
    .ack_o(), .ring_a_i(ring), .host_l2_i(l2), .wake_o(wake4), .baud_tick_o(tick4));

  // Closing verdict, shared by the main sequence and the watchdog
  task automatic wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [8:0] ra(input int port, input int idx);
    return 9'(port * 32 + idx * 4);
  endfunction

  // Expected clocks per strobe from the crystal ratio 14.7456 / 25
  function automatic longint clocks(input int dv, input int s, input int m, input int n);
    longint pre;
    pre = (longint'(1) << (m - 1)) * ((16 - s) + n);
    return (longint'(dv) * pre * 250000) / 147456;
  endfunction

  function automatic bit near(input int got, input longint exp, input int tol);
    return (got >= exp - tol) && (got <= exp + tol);
  endfunction

  // One bus access; waits for the model's completion under a bound
  task automatic wb(input logic w, input logic [8:0] adx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    go <= 1'b1;
    wr <= w;
    a  <= adx;
    wd <= d;
    @(posedge clk_i);
    go <= 1'b0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (done !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      $display("BAD %0t no bus answer", $time);
      wrap_up();
    end
  endtask

  // Cycles until the next strobe of a port, then a check that it lasted one cycle
  task automatic meas(input int port, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge clk_i);
      cnt++;
    end
    while (tick8[port] !== 1'b1 && cnt < 30000);
    @(negedge clk_i);
    `TB_CHK(tick8[port], 1'b0)
  endtask

  // Absent channels of the four-port build never strobe
  always @(negedge clk_i)
    if (!rst_i)
      `TB_CHK(tick4[6:3], 4'h0)

  // Watchdog sized well above the longest strobe runs
  initial
  begin
    #(40 * 90000);
    n_fail++;
    $display("BAD %0t watchdog", $time);
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h2975));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ra(5, 0), 0);
    `TB_CHK(rd, {24'h0, `MUB_RST_DIV_LO})
    wb(0, ra(5, 3), 0);
    `TB_CHK(rd, {24'h0, `MUB_RST_PWR, `MUB_RST_ADD})
    wb(0, 9'h100, 0);
    `TB_CHK(rd, {`MUB_DEV_ID_8P, `MUB_VENDOR_ID})
    `TB_CHK(dat4, {`MUB_DEV_ID_4P, `MUB_VENDOR_ID})
    $display("test reset_id done");
    // Random settings on every port, read back from both builds
    for (int q = 0; q < 8; q++)
    begin
      v[q][0] = 8'($urandom_range(255));
      v[q][1] = 8'($urandom_range(255));
      v[q][2] = 8'($urandom_range(12));
      v[q][3] = {5'($urandom_range(2, 1)), 3'($urandom_range(7))};
      for (int i = 0; i < 4; i++)
        wb(1, ra(q, i), {24'h0, v[q][i]});
    end
    for (int q = 0; q < 8; q++)
      for (int i = 0; i < 4; i++)
      begin
        wb(0, ra(q, i), 0);
        `TB_CHK(rd, {24'h0, v[q][i]})
        `TB_CHK(dat4, (q inside {0, 1, 2, 7}) ? {24'h0, v[q][i]} : 32'h0)
      end
    $display("test map done");
    // Corner cases: setting beyond 0xC, spare slot and address beyond the ports
    wb(1, ra(3, 2), 32'h0f);
    wb(0, ra(3, 2), 0);
    `TB_CHK(rd, {28'h0, `MUB_SAMPLE_MAX})
    wb(1, ra(2, 5), 32'hff);
    wb(0, ra(2, 5), 0);
    `TB_CHK(rd, 32'h0)
    wb(0, 9'h104, 0);
    `TB_CHK(rd, 32'h0)
    $display("test corners done");
    // Strobe timing after reprogramming; first pass uses the high latch
    for (int k = 0; k < 7; k++)
    begin
      p  = $urandom_range(7);
      lo = (k == 0) ? 8'h00 : 8'($urandom_range(31, 1));
      hi = (k == 0) ? 8'h01 : 8'h00;
      sc = (k == 0) ? 4'hc : 4'($urandom_range(12));
      pw = 5'($urandom_range(2, 1));
      ad = (k == 0) ? 3'h0 : 3'($urandom_range(7));
      wb(1, ra(p, 0), {24'h0, lo});
      wb(1, ra(p, 1), {24'h0, hi});
      wb(1, ra(p, 2), {28'h0, sc});
      wb(1, ra(p, 3), {24'h0, pw, ad});
      e = clocks(lo + 256 * hi, sc, pw, ad);
      meas(p, t);
      `TB_CHK(near(t, e, 6), 1'b1)
      meas(p, t);
      `TB_CHK(near(t + 1, e, 2), 1'b1)
    end
    // Last port strobed and is programmed sanely: active and strobe-seen both set
    wb(0, ra(p, 4), 0);
    `TB_CHK(rd, 32'h3)
    $display("test strobes done");
    // Wake-up needs ring and low-power state together
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_i);
      ring <= k[0];
      l2   <= k[1];
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      `TB_CHK(wake8, k[0] & k[1])
      `TB_CHK(wake4, 1'b0)
    end
    $display("test wake done");
    wrap_up();
  end
endmodule
